// [src/tec_pkg.sv]
// ********************************************************************
// Timer/event counter constants
// ********************************************************************
package tec_pkg;
    // Register byte addresses on the internal register port.
    localparam logic [11:0] TEC_ADDR_MODE = 12'hfa0;
    localparam logic [11:0] TEC_ADDR_OUTEN = 12'hfa2;
    localparam logic [11:0] TEC_ADDR_COUNT = 12'hfa4;
    localparam logic [11:0] TEC_ADDR_LIMIT = 12'hfa6;
    localparam logic [11:0] TEC_ADDR_IRQ = 12'hfa8;

    // Mode register fields.
    localparam int TEC_MODE_EN_BIT = 2;
    localparam int TEC_MODE_START_BIT = 3;
    localparam int TEC_MODE_SEL_LSB = 4;
    localparam logic [2:0] TEC_START_BIT_IDX = 3'h3;

    // Reset values.
    localparam logic [7:0] TEC_MODE_RESET = 8'h00;
    localparam logic [7:0] TEC_COUNT_RESET = 8'h00;
    localparam logic [7:0] TEC_LIMIT_RESET = 8'hff;

    // Count pulse source codes.
    localparam logic [2:0] TEC_SEL_EXT_RISE = 3'h0;
    localparam logic [2:0] TEC_SEL_EXT_FALL = 3'h1;
    localparam logic [2:0] TEC_SEL_DIV1024 = 3'h4;
    localparam logic [2:0] TEC_SEL_DIV256 = 3'h5;
    localparam logic [2:0] TEC_SEL_DIV64 = 3'h6;
    localparam logic [2:0] TEC_SEL_DIV16 = 3'h7;

    // Prescaler width: the slowest tap divides the main clock by 1024.
    localparam int TEC_PRESCALE_W = 10;
endpackage

// [src/tec_pulse_gen.sv]
`timescale 1ns/1ps
// ********************************************************************
// Count pulse source: prescaler taps and external input edges
// ********************************************************************
module tec_pulse_gen
    import tec_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] pulse_sel,
    input wire logic external_count_input,
    output logic count_pulse
);

    logic [TEC_PRESCALE_W-1:0] prescale_reg;
    logic ext_prev_reg;

    // True on the last cycle of a divide-by-2^n period.
    function automatic logic tap_hit(input logic [TEC_PRESCALE_W-1:0] cnt,
                                     input int n);
        logic hit;
        hit = 1'b1;
        for (int i = 0; i < TEC_PRESCALE_W; i++) begin
            if (i < n && !cnt[i]) begin
                hit = 1'b0;
            end
        end
        return hit;
    endfunction

    // Free-running prescaler; only reset clears it, so restarts stay cheap.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prescale_reg <= '0;
        end else begin
            prescale_reg <= prescale_reg + 1'b1;
        end
    end

    // The input is already synchronous, so one flop suffices for edges.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_prev_reg <= 1'b0;
        end else begin
            ext_prev_reg <= external_count_input;
        end
    end

    // Source select; prohibited codes give no pulses at all.
    always_comb begin
        case (pulse_sel)
            TEC_SEL_EXT_RISE: count_pulse = external_count_input
                                            && !ext_prev_reg;
            TEC_SEL_EXT_FALL: count_pulse = !external_count_input
                                            && ext_prev_reg;
            TEC_SEL_DIV1024: count_pulse = tap_hit(prescale_reg, 10);
            TEC_SEL_DIV256: count_pulse = tap_hit(prescale_reg, 8);
            TEC_SEL_DIV64: count_pulse = tap_hit(prescale_reg, 6);
            TEC_SEL_DIV16: count_pulse = tap_hit(prescale_reg, 4);
            default: count_pulse = 1'b0;
        endcase
    end

endmodule // tec_pulse_gen

// [src/tec_timer.sv]
`timescale 1ns/1ps
// Operation
// - Mode register is 8 bits, byte written, all zero after reset.
// - Start bit 3 is settable alone and self-clears after the start.
// - Start clears count and irq flag; counting needs enable bit 2.
// - A start write resets the toggle output flop.
// - Every match pulse without a start inverts the toggle output flop.
// - Output enable gates the flop onto the pin; reset clears both.
// - Bits 6:4 select external edge or fx/1024, 256, 64, 16.
// - Count enable low blocks count pulses and holds the count.
// - Count enable high increments the count on each chosen pulse.
// - Pin input, output, limit write, count read, flag work always.
// - The limit register takes a whole byte in one write.
// - Count is readable while running and cannot be loaded.
// - Clocked externally the block divides the input by limit plus one.
// - A shift clock derived from matches feeds the serial unit.
// - Count equal to limit gives a match that toggles and clears.
// - Matches recur every limit plus one count pulses.
module tec_timer
    import tec_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [11:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_bset,
    input wire logic reg_bclr,
    input wire logic [2:0] reg_bit,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic external_count_input,
    output logic ext_input_level,
    output logic timer_output_pin,
    output logic serial_shift_clk,
    output logic timer_irq_flag
);

    // ****************************************************************
    // Register state
    // ****************************************************************
    logic [7:0] timer_mode_control_reg;
    logic toggle_out_enable_flag_reg;
    logic [7:0] count_value_reg;
    logic [7:0] compare_limit_reg;
    logic timer_irq_flag_reg;
    logic toggle_output_flop_reg;
    logic [7:0] reg_rdata_reg;
    logic ext_level_reg;
    logic count_pulse;
    logic [7:0] mode_next;
    logic [7:0] mode_store;
    logic [7:0] outen_next;
    logic start;
    logic counting;
    logic match;
    logic irq_clr;

    // Applies byte writes and single-bit set or clear to an 8-bit value.
    function automatic logic [7:0] reg_update(input logic [7:0] cur,
                                              input logic wr,
                                              input logic [7:0] wd,
                                              input logic bs,
                                              input logic bc,
                                              input logic [2:0] b);
        logic [7:0] v;
        v = cur;
        if (wr) begin
            v = wd;
        end else if (bs) begin
            v[b] = 1'b1;
        end else if (bc) begin
            v[b] = 1'b0;
        end
        return v;
    endfunction

    // ****************************************************************
    // Register decode
    // ****************************************************************
    // Starting is any byte write or bit set that leaves bit 3 at one.
    // The stored start bit follows the start strobe, so a later bit clear
    // of another mode bit cannot leave a stale start bit standing.
    always_comb begin
        mode_next = reg_update(timer_mode_control_reg, reg_wr, reg_wdata,
                               reg_bset, reg_bclr, reg_bit);
        start = (reg_addr == TEC_ADDR_MODE) && (reg_wr || reg_bset)
                && mode_next[TEC_MODE_START_BIT];
        mode_store = mode_next;
        mode_store[TEC_MODE_START_BIT] = start;
    end

    // Next output enable value; only bit 0 of the flag address is kept.
    assign outen_next = reg_update({7'h00, toggle_out_enable_flag_reg},
                                   reg_wr, reg_wdata,
                                   reg_bset && reg_bit == 3'h0,
                                   reg_bclr && reg_bit == 3'h0, 3'h0);

    assign irq_clr = (reg_addr == TEC_ADDR_IRQ) && ((reg_wr && !reg_wdata[0])
                     || (reg_bclr && reg_bit == 3'h0));

    // Mode register; the start bit drops one cycle after it was set.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timer_mode_control_reg <= TEC_MODE_RESET;
        end else if (reg_addr == TEC_ADDR_MODE
                     && (reg_wr || reg_bset || reg_bclr)) begin
            timer_mode_control_reg <= mode_store;
        end else if (timer_mode_control_reg[TEC_MODE_START_BIT]) begin
            timer_mode_control_reg[TEC_MODE_START_BIT] <= 1'b0;
        end
    end

    // Output enable flag, byte or bit writable at any time.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            toggle_out_enable_flag_reg <= 1'b0;
        end else if (reg_addr == TEC_ADDR_OUTEN) begin
            toggle_out_enable_flag_reg <= outen_next[0];
        end
    end

    // Limit register takes whole bytes only; zero is the caller's fault.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            compare_limit_reg <= TEC_LIMIT_RESET;
        end else if (reg_addr == TEC_ADDR_LIMIT && reg_wr) begin
            compare_limit_reg <= reg_wdata;
        end
    end

    // Registered read data; the count register has no write path.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata_reg <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                TEC_ADDR_MODE: reg_rdata_reg <= timer_mode_control_reg;
                TEC_ADDR_OUTEN: reg_rdata_reg <= {7'h00,
                                                  toggle_out_enable_flag_reg};
                TEC_ADDR_COUNT: reg_rdata_reg <= count_value_reg;
                TEC_ADDR_LIMIT: reg_rdata_reg <= compare_limit_reg;
                TEC_ADDR_IRQ: reg_rdata_reg <= {7'h00, timer_irq_flag_reg};
                default: reg_rdata_reg <= 8'h00;
            endcase
        end
    end

    // Sampled pin level for software test, in any mode.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_level_reg <= 1'b0;
        end else begin
            ext_level_reg <= external_count_input;
        end
    end

    // ****************************************************************
    // Counting
    // ****************************************************************
    tec_pulse_gen u_pulse (
        .clk(clk),
        .rst(rst),
        .pulse_sel(timer_mode_control_reg[TEC_MODE_SEL_LSB +: 3]),
        .external_count_input(external_count_input),
        .count_pulse(count_pulse)
    );

    // Enable gates the pulse; a match on the pulse that ends period N+1.
    assign counting = count_pulse
                      && timer_mode_control_reg[TEC_MODE_EN_BIT];
    assign match = counting && (count_value_reg == compare_limit_reg);

    // Count register; start wins over a coinciding pulse.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_value_reg <= TEC_COUNT_RESET;
        end else if (start) begin
            count_value_reg <= 8'h00;
        end else if (match) begin
            count_value_reg <= 8'h00;
        end else if (counting) begin
            count_value_reg <= count_value_reg + 8'h01;
        end
    end

    // Toggle flop doubles as the divided output and the shift clock.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            toggle_output_flop_reg <= 1'b0;
        end else if (start) begin
            toggle_output_flop_reg <= 1'b0;
        end else if (match) begin
            toggle_output_flop_reg <= !toggle_output_flop_reg;
        end
    end

    // Interrupt flag: a match outranks a software clear in the same cycle.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timer_irq_flag_reg <= 1'b0;
        end else if (start) begin
            timer_irq_flag_reg <= 1'b0;
        end else if (match) begin
            timer_irq_flag_reg <= 1'b1;
        end else if (reg_addr == TEC_ADDR_IRQ
                     && ((reg_wr && reg_wdata[0])
                     || (reg_bset && reg_bit == 3'h0))) begin
            timer_irq_flag_reg <= 1'b1;
        end else if (irq_clr) begin
            timer_irq_flag_reg <= 1'b0;
        end
    end

    assign reg_rdata = reg_rdata_reg;
    assign ext_input_level = ext_level_reg;
    assign timer_output_pin = toggle_output_flop_reg
                              && toggle_out_enable_flag_reg;
    assign serial_shift_clk = toggle_output_flop_reg;
    assign timer_irq_flag = timer_irq_flag_reg;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence s_start_cmd;
        start;
    endsequence

    sequence s_all_cleared;
        count_value_reg == 8'h00 && !toggle_output_flop_reg
        && !timer_irq_flag_reg;
    endsequence

    a_start_clears: assert property (@(posedge clk) disable iff (rst)
        s_start_cmd |=> s_all_cleared)
        else $error("start did not clear count, flop and flag");

    a_start_selfclear: assert property (@(posedge clk)
        disable iff (rst)
        s_start_cmd ##1 !start
        |=> !timer_mode_control_reg[TEC_MODE_START_BIT])
        else $error("start bit did not return to zero");

    a_match_toggle: assert property (@(posedge clk) disable iff (rst)
        match && !start |=> toggle_output_flop_reg != $past(
            toggle_output_flop_reg) && count_value_reg == 8'h00
            && timer_irq_flag_reg)
        else $error("match did not toggle, clear and flag");

    a_halt_hold: assert property (@(posedge clk) disable iff (rst)
        !timer_mode_control_reg[TEC_MODE_EN_BIT] && !start
        |=> $stable(count_value_reg))
        else $error("count moved while disabled");

    a_count_step: assert property (@(posedge clk) disable iff (rst)
        counting && !match && !start
        |=> count_value_reg == $past(count_value_reg) + 8'h01)
        else $error("count did not step by one");

    a_pin_gate: assert property (@(posedge clk) disable iff (rst)
        timer_output_pin == (toggle_output_flop_reg
                             && toggle_out_enable_flag_reg))
        else $error("output pin not gated by enable");

    a_irq_sticky: assert property (@(posedge clk) disable iff (rst)
        timer_irq_flag_reg && !start && !irq_clr |=> timer_irq_flag_reg)
        else $error("irq flag dropped without a clear");

    a_limit_load: assert property (@(posedge clk) disable iff (rst)
        reg_wr && reg_addr == TEC_ADDR_LIMIT
        |=> compare_limit_reg == $past(reg_wdata))
        else $error("limit register missed a byte write");

    a_ext_rise: assert property (@(posedge clk) disable iff (rst)
        timer_mode_control_reg[TEC_MODE_SEL_LSB +: 3] == TEC_SEL_EXT_RISE
        && timer_mode_control_reg[TEC_MODE_EN_BIT]
        && $rose(external_count_input) && !start && !match
        |=> count_value_reg == $past(count_value_reg) + 8'h01)
        else $error("rising input edge not counted");

endmodule // tec_timer

// [tb/tec_sw_model.sv]
`timescale 1ns/1ps
// ****************************************
// Software and event pin model
// ****************************************
module tec_sw_model (
    input wire logic clk,
    output logic [11:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_bset,
    output logic reg_bclr,
    output logic [2:0] reg_bit,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata,
    output logic external_count_input
);
    // All strobes idle from time zero until the first request.
    initial begin
        {reg_addr, reg_wdata, reg_bit} = 23'h0;
        {reg_wr, reg_bset, reg_bclr, reg_rd} = 4'h0;
        external_count_input = 1'b0;
    end

    // One strobe cycle, then the lines are scrambled so stale values
    // can never pass for a live request.
    task automatic op(input logic [11:0] a, input logic [7:0] d,
                      input logic [3:0] s, input logic [2:0] b);
        @(negedge clk);
        {reg_addr, reg_wdata, reg_bit} = {a, d, b};
        {reg_wr, reg_bset, reg_bclr, reg_rd} = s;
        @(negedge clk);
        {reg_wr, reg_bset, reg_bclr, reg_rd} = 4'h0;
        {reg_addr, reg_wdata, reg_bit} = ~{a, d, b};
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        op(a, d, 4'h8, 3'h0);
    endtask

    task automatic bset(input logic [11:0] a, input logic [2:0] b);
        op(a, 8'h00, 4'h4, b);
    endtask

    task automatic bclr(input logic [11:0] a, input logic [2:0] b);
        op(a, 8'h00, 4'h2, b);
    endtask

    // Read data is taken in the cycle after the strobe, while it stands.
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        op(a, 8'h00, 4'h1, 3'h0);
        d = reg_rdata;
    endtask

    // Event pin level, held long enough for the synchronous sampler.
    task automatic pin(input logic v);
        @(negedge clk);
        external_count_input = v;
        repeat (2) @(negedge clk);
    endtask
endmodule // tec_sw_model

// [tb/tec_timer_bench.sv]
`timescale 1ns/1ps
// ****************************************
// Timer/event counter bench
// ****************************************
module tec_timer_bench import tec_pkg::*; ;
    logic clk, rst, reg_wr, reg_bset, reg_bclr, reg_rd, ext_in;
    logic [11:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic [2:0] reg_bit;
    logic ext_input_level, timer_output_pin, serial_shift_clk;
    logic timer_irq_flag;
    int err_count = 0;
    int n_tests = 0;
    int cycles = 0;

    tec_timer tec_timer_inst (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_bset(reg_bset),
        .reg_bclr(reg_bclr), .reg_bit(reg_bit), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .external_count_input(ext_in),
        .ext_input_level(ext_input_level),
        .timer_output_pin(timer_output_pin),
        .serial_shift_clk(serial_shift_clk),
        .timer_irq_flag(timer_irq_flag));
    tec_sw_model m (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_bset(reg_bset), .reg_bclr(reg_bclr),
        .reg_bit(reg_bit), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .external_count_input(ext_in));

    // Clock at 20 MHz.
    initial clk = 1'b0;
    always #25 clk = ~clk;

    // A hang is cut short well past the longest expected run.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            err_count++;
            conclude();
        end
    end

    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Counts falling edges until the shift clock changes level.
    task automatic wait_toggle(output logic [15:0] n);
        logic last;
        last = serial_shift_clk;
        n = 16'h0;
        while (serial_shift_clk === last && n < 16'h1000) begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        logic [7:0] d;
        m.rd(TEC_ADDR_MODE, d);
        chk(d, TEC_MODE_RESET);
        m.rd(TEC_ADDR_OUTEN, d);
        chk(d, 16'h0);
        m.rd(TEC_ADDR_COUNT, d);
        chk(d, TEC_COUNT_RESET);
        chk({timer_output_pin, serial_shift_clk}, 16'h0);
        chk(timer_irq_flag, 16'h0);
        $display("test reset done");
    endtask

    // Limit first, then mode with fx/16, enable and start.
    task automatic t_interval();
        logic [7:0] d;
        logic [15:0] n;
        m.wr(TEC_ADDR_LIMIT, 8'h03);
        m.wr(TEC_ADDR_MODE, 8'h7c);
        m.rd(TEC_ADDR_MODE, d);
        chk(d, 8'h74);
        m.rd(TEC_ADDR_COUNT, d);
        chk(d <= 8'h03, 16'h1);
        wait_toggle(n);
        wait_toggle(n);
        chk(n, 16'd64);
        chk(timer_irq_flag, 16'h1);
        chk(timer_output_pin, 16'h0);
        m.wr(TEC_ADDR_OUTEN, 8'h01);
        chk(timer_output_pin, 16'h0);
        wait_toggle(n);
        chk(timer_output_pin, 16'h1);
        chk(serial_shift_clk, 16'h1);
        $display("test interval done");
    endtask

    // Restart by a single bit set while the flop is high.
    task automatic t_restart();
        logic [15:0] n;
        if (serial_shift_clk !== 1'b1) wait_toggle(n);
        m.bset(TEC_ADDR_MODE, TEC_START_BIT_IDX);
        chk(serial_shift_clk, 16'h0);
        chk(timer_irq_flag, 16'h0);
        m.wr(TEC_ADDR_IRQ, 8'h01);
        chk(timer_irq_flag, 16'h1);
        m.bclr(TEC_ADDR_IRQ, 3'h0);
        chk(timer_irq_flag, 16'h0);
        $display("test restart done");
    endtask

    // Every prescaled source with limit 1 gives twice its divide.
    task automatic t_codes();
        logic [2:0] code [4] = '{3'h4, 3'h5, 3'h6, 3'h7};
        logic [15:0] dv [4] = '{16'd1024, 16'd256, 16'd64, 16'd16};
        logic [15:0] n;
        for (int i = 0; i < 4; i++) begin
            m.wr(TEC_ADDR_LIMIT, 8'h01);
            m.wr(TEC_ADDR_MODE, {1'b0, code[i], 4'hc});
            wait_toggle(n);
            wait_toggle(n);
            chk(n, dv[i] << 1);
        end
        $display("test codes done");
    endtask

    // Enable low holds the count; the count address refuses writes.
    task automatic t_hold();
        logic [7:0] a, b;
        m.wr(TEC_ADDR_MODE, 8'h70);
        m.rd(TEC_ADDR_COUNT, a);
        repeat (100) @(negedge clk);
        m.wr(TEC_ADDR_COUNT, ~a);
        m.rd(TEC_ADDR_COUNT, b);
        chk(b, a);
        $display("test hold done");
    endtask

    // Event counting on both edges and division of the pin by three.
    task automatic t_event();
        logic [7:0] d;
        m.wr(TEC_ADDR_LIMIT, 8'h02);
        m.wr(TEC_ADDR_MODE, 8'h0c);
        repeat (2) begin
            m.pin(1'b1);
            m.pin(1'b0);
        end
        m.rd(TEC_ADDR_COUNT, d);
        chk(d, 8'h02);
        m.pin(1'b1);
        chk(ext_input_level, 16'h1);
        chk(timer_output_pin, 16'h1);
        m.rd(TEC_ADDR_COUNT, d);
        chk(d, 8'h00);
        m.wr(TEC_ADDR_MODE, 8'h1c);
        m.pin(1'b0);
        m.pin(1'b1);
        m.rd(TEC_ADDR_COUNT, d);
        chk(d, 8'h01);
        $display("test event done");
    endtask

    // Reset for four cycles, then the scenarios in turn.
    initial begin
        rst = 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_interval();
        t_restart();
        t_codes();
        t_hold();
        t_event();
        conclude();
    end
endmodule // tec_timer_bench
